// ===== pkg/lst_cfg.svh
// Purpose: constants of the single-wire frame link, both ends
// Assumes: 50 MHz clock, fixed nominal bit rate
// Notes: included by the package, master and slave files of the link
`ifndef LST_CFG_SVH
`define LST_CFG_SVH

// ----------------------------------------------------------------
// Timing and data item counts
// ----------------------------------------------------------------
`define LST_CLK_HZ 50000000
`define LST_BAUD 19200
`define LST_BIT_CYC (`LST_CLK_HZ / `LST_BAUD)
`define LST_BREAK_TX_BITS 13
`define LST_BREAK_DET_BITS 11
`define LST_HDR_NOM_BITS 34
`define LST_RESP_BITS_PER 10
`define LST_MAX_NUM 14
`define LST_MAX_DEN 10
`define LST_ITEMS_MAX 8
`define LST_ITEMS_RST 4'h8

// ----------------------------------------------------------------
// Frame bytes, reset values and count saturation
// ----------------------------------------------------------------
`define LST_SYNC_BYTE 8'h55
`define LST_OC_RST 8'hff
`define LST_CNT_SAT 8'hff

// ----------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------
`define LST_A_SMC 8'h00
`define LST_A_TCS 8'h04
`define LST_A_OCR 8'h08
`define LST_A_NDAT 8'h0c
`define LST_A_RXD 8'h10
`define LST_A_STS 8'h14
`define LST_A_CLR 8'h18
`define LST_A_EN 8'h1c
`define LST_TCS_MODE 0
`define LST_TCS_IDLE_TO 1
`define LST_IRQ_TO 0
`define LST_IRQ_SYNC 1
`define LST_IRQ_DONE 2
`define LST_IRQ_HDR 3
`define LST_IRQ_W 4

`endif

// ===== pkg/lst_if.sv
// Purpose: single-wire bus joining master and slave
// Assumes: both ends open-drain, dominant level low
// Notes: wire level resolved here from the enables
`timescale 1ns/1ps
interface lst_if;
	logic m_tx;
	logic m_oe;
	logic s_tx;
	logic s_oe;
	logic bus;

	// Wired-and, recessive high
	assign bus = ~((m_oe & ~m_tx) | (s_oe & ~s_tx));

	modport dev (input bus, output s_tx, output s_oe);
	modport mst (input bus, output m_tx, output m_oe);
endinterface

// ===== pkg/lst_pkg.sv
// Purpose: types and shared arithmetic of the frame link
// Assumes: constants from lst_cfg.svh
// Notes: none
`include "lst_cfg.svh"
package lst_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SYNC = 4'h2,
		ST_PID = 4'h4,
		ST_DATA = 4'h8
	} lst_sstate_t;

	typedef enum logic [4:0] {
		MS_IDLE = 5'h01,
		MS_BRK = 5'h02,
		MS_DEL = 5'h04,
		MS_BYTE = 5'h08,
		MS_GAP = 5'h10
	} lst_mstate_t;

	// Header maximum in bits, rounded up
	function automatic logic [7:0] lst_hdr_max();
		lst_hdr_max = 8'((`LST_HDR_NOM_BITS * `LST_MAX_NUM + `LST_MAX_DEN - 1) / `LST_MAX_DEN);
	endfunction

	// Header maximum plus response maximum
	function automatic logic [7:0] lst_frame_max(input logic [3:0] n);
		logic [7:0] r;
		r = 8'((`LST_RESP_BITS_PER * (32'(n) + 1) * `LST_MAX_NUM + `LST_MAX_DEN - 1)
			/ `LST_MAX_DEN);
		lst_frame_max = lst_hdr_max() + r;
	endfunction

	// Sum with end-around carry
	function automatic logic [7:0] lst_csum_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		lst_csum_add = s[7:0] + {7'h00, s[8]};
	endfunction
endpackage

// ===== rtl/lst_master.sv
// Purpose: master end, sends header and publisher response
// Assumes: user holds I_DATA valid until O_DATA_TAKE
// Notes: next header held back for the max frame time
`timescale 1ns/1ps
`include "lst_cfg.svh"
module lst_master import lst_pkg::*; #(
	parameter int BIT_CYC = `LST_BIT_CYC
) (
	// Clock and reset
	input wire logic I_MCLK,
	input wire logic I_RESET,
	// Frame request
	input wire logic I_START,
	input wire logic [7:0] I_PID,
	input wire logic [3:0] I_COUNT,
	output logic O_READY,
	// Response data
	input wire logic [7:0] I_DATA,
	output logic O_DATA_TAKE,
	// Bus
	lst_if.mst LINK
);
	if (BIT_CYC < 4 || BIT_CYC > 65535) begin : g_chk
		$error("BIT_CYC out of range");
	end

	lst_mstate_t state_reg, state_next;
	logic [15:0] pre_reg;
	logic [3:0] bit_reg;
	logic [3:0] idx_reg;
	logic [3:0] n_reg;
	logic [7:0] pid_reg;
	logic [7:0] sum_reg;
	logic [9:0] sh_reg;
	logic [7:0] frm_reg;
	logic tx_reg;
	logic take_reg;

	wire tick = (pre_reg == 16'(BIT_CYC - 1));
	wire byte_end = (state_reg == MS_BYTE) && tick && (bit_reg == 4'h9);
	wire last_byte = (idx_reg == n_reg + 4'h2);
	// Checksum loaded once the last data item has gone out
	wire sum_due = (idx_reg == n_reg + 4'h1);
	wire [7:0] data_byte = sum_due ? ~sum_reg : I_DATA;
	wire [7:0] next_byte = (idx_reg == 4'h0) ? pid_reg : data_byte;
	wire take_now = byte_end && (idx_reg >= 4'h1) && (idx_reg < n_reg + 4'h1);
	wire [3:0] n_clamp = (I_COUNT > 4'(`LST_ITEMS_MAX)) ? 4'(`LST_ITEMS_MAX) : I_COUNT;
	// hold next header until max frame time
	wire gap_done = (frm_reg >= lst_frame_max(n_reg));

	assign O_READY = (state_reg == MS_IDLE);
	assign O_DATA_TAKE = take_reg;
	assign LINK.m_tx = tx_reg;
	assign LINK.m_oe = ~tx_reg;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			MS_IDLE: begin
				if (I_START) begin
					state_next = MS_BRK;
				end
			end
			MS_BRK: begin
				if (tick && bit_reg == 4'(`LST_BREAK_TX_BITS - 1)) begin
					state_next = MS_DEL;
				end
			end
			MS_DEL: begin
				if (tick) begin
					state_next = MS_BYTE;
				end
			end
			MS_BYTE: begin
				if (byte_end && last_byte) begin
					state_next = MS_GAP;
				end
			end
			MS_GAP: begin
				if (gap_done) begin
					state_next = MS_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			state_reg <= MS_IDLE;
			pre_reg <= 16'h0000;
			bit_reg <= 4'h0;
			idx_reg <= 4'h0;
			n_reg <= 4'h0;
			pid_reg <= 8'h00;
			sum_reg <= 8'h00;
			sh_reg <= 10'h3ff;
			frm_reg <= 8'h00;
			tx_reg <= 1'b1;
			take_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			take_reg <= take_now;
			pre_reg <= (state_reg == MS_IDLE || tick) ? 16'h0000 : pre_reg + 16'h0001;
			if (state_reg == MS_IDLE) begin
				pid_reg <= I_PID;
				n_reg <= n_clamp;
				frm_reg <= 8'h00;
				bit_reg <= 4'h0;
				idx_reg <= 4'h0;
				sum_reg <= 8'h00;
			end else if (tick && frm_reg != `LST_CNT_SAT) begin
				frm_reg <= frm_reg + 8'h01;
			end
			if (state_reg == MS_BRK && tick) begin
				bit_reg <= (state_next == MS_DEL) ? 4'h0 : bit_reg + 4'h1;
			end
			if (state_reg == MS_DEL && tick) begin
				sh_reg <= {1'b1, `LST_SYNC_BYTE, 1'b0};
			end
			if (state_reg == MS_BYTE && tick) begin
				if (bit_reg == 4'h9) begin
					bit_reg <= 4'h0;
					idx_reg <= idx_reg + 4'h1;
					sh_reg <= {1'b1, next_byte, 1'b0};
					if (take_now) begin
						sum_reg <= lst_csum_add(sum_reg, I_DATA);
					end
				end else begin
					bit_reg <= bit_reg + 4'h1;
					sh_reg <= {1'b1, sh_reg[9:1]};
				end
			end
			tx_reg <= (state_next == MS_BRK) ? 1'b0 :
				(state_next == MS_BYTE) ? ((state_reg == MS_DEL) ? 1'b0 :
				(tick ? ((bit_reg == 4'h9) ? 1'b0 : sh_reg[1]) : tx_reg)) : 1'b1;
		end
	end
endmodule

// ===== rtl/lst_slave.sv
// Purpose: slave frame machine with timeout counter and APB registers
// Assumes: receive-only slave, response published by the master
// Notes: bus input filtered by three flops
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "lst_cfg.svh"
module lst_slave import lst_pkg::*; #(
	parameter int BIT_CYC = `LST_BIT_CYC,
	parameter int BRK_CYC = `LST_BREAK_DET_BITS * `LST_BIT_CYC
) (
	// Clock and reset
	input wire logic I_MCLK,
	input wire logic I_RESET,
	// APB slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// Interrupt
	output logic O_IRQ,
	// Bus
	lst_if.dev LINK
);
	if (BIT_CYC < 4 || BIT_CYC > 65535 || BRK_CYC <= BIT_CYC * 9 || BRK_CYC > 65535) begin : g_chk
		$error("bit or break timing out of range");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	lst_sstate_t state_reg, state_next;
	logic rx_s1_reg, rx_s2_reg, rx_s3_reg, rx_reg;
	logic brk_reg, rcv_reg, byte_ok_reg, cnt_upd_reg;
	logic lin_sel_reg, mode_reg, idle_on_timeout_reg;
	logic [15:0] low_reg, rcy_reg, pre_reg;
	logic [3:0] rbit_reg, ndat_reg, idx_reg;
	logic [7:0] rsh_reg, cnt_reg, pid_reg, last_reg;
	logic [7:0] compare_value_first_reg, compare_value_second_reg;
	logic [`LST_IRQ_W-1:0] sts_reg, en_reg;
	logic [31:0] prdata_reg;

	// ----------------------------------------------------------------
	// Bus input and break detect
	// ----------------------------------------------------------------
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			rx_s3_reg <= 1'b1;
			rx_reg <= 1'b1;
		end else begin
			rx_s1_reg <= LINK.bus;
			rx_s2_reg <= rx_s1_reg;
			rx_s3_reg <= rx_s2_reg;
			if (rx_s2_reg == rx_s3_reg) begin
				rx_reg <= rx_s3_reg;
			end
		end
	end

	wire brk_hit = (low_reg == 16'(BRK_CYC - 1)) && !rx_reg;
	wire brk_done = brk_reg && rx_reg && lin_sel_reg;

	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			low_reg <= 16'h0000;
			brk_reg <= 1'b0;
		end else begin
			low_reg <= rx_reg ? 16'h0000 : (brk_hit ? low_reg : low_reg + 16'h0001);
			brk_reg <= brk_hit | (brk_reg & !rx_reg);
		end
	end

	// ----------------------------------------------------------------
	// Byte receiver
	// ----------------------------------------------------------------
	wire rsample = rcv_reg && (rcy_reg == 16'h0000);
	wire rstart = !rcv_reg && !rx_reg && !brk_reg && !brk_hit;

	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			rcv_reg <= 1'b0;
			rcy_reg <= 16'h0000;
			rbit_reg <= 4'h0;
			rsh_reg <= 8'h00;
			byte_ok_reg <= 1'b0;
		end else begin
			byte_ok_reg <= rsample && (rbit_reg == 4'h9) && rx_reg;
			if (brk_hit || brk_reg) begin
				rcv_reg <= 1'b0;
			end else if (rstart) begin
				rcv_reg <= 1'b1;
				rcy_reg <= 16'(BIT_CYC / 2);
				rbit_reg <= 4'h0;
			end else if (rcv_reg) begin
				rcy_reg <= rsample ? 16'(BIT_CYC - 1) : rcy_reg - 16'h0001;
				if (rsample) begin
					rbit_reg <= rbit_reg + 4'h1;
					if (rbit_reg >= 4'h1 && rbit_reg <= 4'h8) begin
						rsh_reg <= {rx_reg, rsh_reg[7:1]};
					end
					if ((rbit_reg == 4'h0 && rx_reg) || rbit_reg == 4'h9) begin
						rcv_reg <= 1'b0;
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Timeout counter
	// ----------------------------------------------------------------
	wire bit_tick = (pre_reg == 16'(BIT_CYC - 1));
	wire in_hdr = (state_reg == ST_SYNC) || (state_reg == ST_PID);
	wire hit1 = (cnt_reg == compare_value_first_reg);
	wire hit2 = (cnt_reg == compare_value_second_reg);
	// match after a count step raises timeout
	wire to_evt = cnt_upd_reg && (mode_reg ? (hit1 | hit2) :
		((in_hdr & hit1) | ((state_reg == ST_DATA) & hit2)));

	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			pre_reg <= 16'h0000;
			cnt_reg <= 8'h00;
			cnt_upd_reg <= 1'b0;
		end else begin
			cnt_upd_reg <= bit_tick && (state_reg != ST_IDLE) && (cnt_reg != `LST_CNT_SAT);
			if (brk_done) begin
				pre_reg <= 16'h0000;
				cnt_reg <= 8'h00;
			end else if (state_reg != ST_IDLE) begin
				pre_reg <= bit_tick ? 16'h0000 : pre_reg + 16'h0001;
				if (bit_tick && cnt_reg != `LST_CNT_SAT) begin
					cnt_reg <= cnt_reg + 8'h01;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Frame state machine
	// ----------------------------------------------------------------
	wire sync_bad = (state_reg == ST_SYNC) && byte_ok_reg && (rsh_reg != `LST_SYNC_BYTE);
	wire frame_done = (state_reg == ST_DATA) && byte_ok_reg && (idx_reg == ndat_reg);
	wire to_idle = to_evt && idle_on_timeout_reg;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: state_next = ST_IDLE;
			ST_SYNC: state_next = !byte_ok_reg ? ST_SYNC : (sync_bad ? ST_IDLE : ST_PID);
			// advance only on full identifier byte
			ST_PID: state_next = byte_ok_reg ? ST_DATA : ST_PID;
			ST_DATA: state_next = frame_done ? ST_IDLE : ST_DATA;
		endcase
		if (to_idle) begin
			state_next = ST_IDLE;
		end
		if (brk_done) begin
			state_next = ST_SYNC;
		end
		if (!lin_sel_reg) begin
			state_next = ST_IDLE;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			state_reg <= ST_IDLE;
			idx_reg <= 4'h0;
			pid_reg <= 8'h00;
			last_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			// timeout or new header drops partial data
			if (brk_done || to_idle || state_reg == ST_PID) begin
				idx_reg <= 4'h0;
			end else if (state_reg == ST_DATA && byte_ok_reg) begin
				idx_reg <= idx_reg + 4'h1;
				last_reg <= rsh_reg;
			end
			if (state_reg == ST_PID && byte_ok_reg && !to_idle && !brk_done) begin
				pid_reg <= rsh_reg;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	wire addr_ok = (I_PADDR[1:0] == 2'b00) && (I_PADDR <= `LST_A_EN);
	wire wr = I_PSEL && I_PENABLE && I_PWRITE && addr_ok;
	wire wr_smc = wr && (I_PADDR == `LST_A_SMC);
	wire wr_tcs = wr && (I_PADDR == `LST_A_TCS);
	wire wr_ocr = wr && (I_PADDR == `LST_A_OCR);
	wire wr_ndat = wr && (I_PADDR == `LST_A_NDAT);
	wire wr_clr = wr && (I_PADDR == `LST_A_CLR);
	wire wr_en = wr && (I_PADDR == `LST_A_EN);
	wire [3:0] nd_w = (I_PWDATA[3:0] > 4'(`LST_ITEMS_MAX)) ? 4'(`LST_ITEMS_MAX) : I_PWDATA[3:0];
	wire [`LST_IRQ_W-1:0] evt;
	wire [`LST_IRQ_W-1:0] clr_m = wr_clr ? I_PWDATA[`LST_IRQ_W-1:0] : '0;
	wire [31:0] rd_mux =
		(I_PADDR == `LST_A_SMC) ? {31'h0, lin_sel_reg} :
		(I_PADDR == `LST_A_TCS) ?
			{12'h000, state_reg, cnt_reg, 6'h00, idle_on_timeout_reg, mode_reg} :
		(I_PADDR == `LST_A_OCR) ? {16'h0000, compare_value_second_reg, compare_value_first_reg} :
		(I_PADDR == `LST_A_NDAT) ? {28'h0, ndat_reg} :
		(I_PADDR == `LST_A_RXD) ? {16'h0000, last_reg, pid_reg} :
		(I_PADDR == `LST_A_STS) ? {28'h0, sts_reg} :
		(I_PADDR == `LST_A_EN) ? {28'h0, en_reg} : 32'h0000_0000;

	assign evt[`LST_IRQ_TO] = to_evt;
	assign evt[`LST_IRQ_SYNC] = sync_bad;
	assign evt[`LST_IRQ_DONE] = frame_done;
	assign evt[`LST_IRQ_HDR] = brk_done;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = I_PSEL && I_PENABLE && !addr_ok;
	assign O_PRDATA = prdata_reg;
	assign O_IRQ = |(sts_reg & en_reg);
	assign LINK.s_tx = 1'b1;
	assign LINK.s_oe = 1'b0;

	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			lin_sel_reg <= 1'b0;
			mode_reg <= 1'b0;
			idle_on_timeout_reg <= 1'b0;
			compare_value_first_reg <= `LST_OC_RST;
			compare_value_second_reg <= `LST_OC_RST;
			ndat_reg <= `LST_ITEMS_RST;
			sts_reg <= '0;
			en_reg <= '0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			if (I_PSEL && !I_PENABLE) begin
				prdata_reg <= addr_ok ? rd_mux : 32'h0000_0000;
			end
			if (wr_smc) begin
				lin_sel_reg <= I_PWDATA[0];
			end
			if (wr_tcs) begin
				mode_reg <= I_PWDATA[`LST_TCS_MODE];
				idle_on_timeout_reg <= I_PWDATA[`LST_TCS_IDLE_TO];
			end
			// header and frame budgets loaded per header when mode_reg is 0
			if (brk_done && !mode_reg) begin
				compare_value_first_reg <= lst_hdr_max();
				compare_value_second_reg <= lst_frame_max(ndat_reg);
			end else if (wr_ocr) begin
				compare_value_first_reg <= I_PWDATA[7:0];
				compare_value_second_reg <= I_PWDATA[15:8];
			end
			if (wr_ndat) begin
				ndat_reg <= nd_w;
			end
			if (wr_en) begin
				en_reg <= I_PWDATA[`LST_IRQ_W-1:0];
			end
			// Set wins over clear
			sts_reg <= (sts_reg & ~clr_m) | evt;
		end
	end
endmodule

// ===== sim/lin_slave_timeout_fsm_test.sv
// Purpose: master frames into one slave, raw driver into a second
// Assumes: bit time 16 cycles, break detect 176 cycles
// Notes: the raw driver aborts and stalls frames on purpose
`timescale 1ns/1ps
module lin_slave_timeout_fsm_test;
	localparam int BC = 16;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic [1:0] psel = 2'h0;
	logic pen = 1'b0;
	logic pw = 1'b0;
	logic [7:0] pa = 8'h00;
	logic [31:0] pd = 32'h0;
	logic [31:0] rd1, rd2;
	logic rdy1, rdy2, err1, err2, irq1, irq2, ready, take;
	int n_fail = 0;
	int tests_run = 0;
	int n_take = 0;
	int k, f;
	lst_if i_lst_if();
	lst_if i_lst_if_2();
	lst_master #(.BIT_CYC(BC)) i_lst_master (.I_MCLK(clk), .I_RESET(rst), .I_START(start),
		.I_PID(8'h2a), .I_COUNT(4'h1), .O_READY(ready), .I_DATA(8'h3c),
		.O_DATA_TAKE(take), .LINK(i_lst_if.mst));
	lst_slave #(.BIT_CYC(BC), .BRK_CYC(176)) i_lst_slave (.I_MCLK(clk), .I_RESET(rst),
		.I_PSEL(psel[0]), .I_PENABLE(pen), .I_PWRITE(pw), .I_PADDR(pa), .I_PWDATA(pd),
		.O_PRDATA(rd1), .O_PREADY(rdy1), .O_PSLVERR(err1), .O_IRQ(irq1), .LINK(i_lst_if.dev));
	lst_slave #(.BIT_CYC(BC), .BRK_CYC(176)) i_lst_slave_2 (.I_MCLK(clk), .I_RESET(rst),
		.I_PSEL(psel[1]), .I_PENABLE(pen), .I_PWRITE(pw), .I_PADDR(pa), .I_PWDATA(pd),
		.O_PRDATA(rd2), .O_PREADY(rdy2), .O_PSLVERR(err2), .O_IRQ(irq2), .LINK(i_lst_if_2.dev));
	lst_checker #(.BIT_CYC(BC)) i_lst_checker (.I_MCLK(clk), .I_RESET(rst),
		.m_tx(i_lst_if.m_tx), .m_oe(i_lst_if.m_oe), .s_tx(i_lst_if.s_tx),
		.s_oe(i_lst_if.s_oe), .bus(i_lst_if.bus));

	initial begin
		forever #10 clk = ~clk;
	end

	// Data fetch pulses, one per data item
	always @(posedge clk) begin
		if (take === 1'b1) begin
			n_take++;
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic apb(input int s, input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [32:0] r);
		int n;
		psel[s] <= 1'b1;
		pw <= w;
		pa <= a;
		pd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		for (n = 0; n < 8 && (s == 1 ? rdy2 : rdy1) !== 1'b1; n++) @(posedge clk);
		if (n == 8) begin
			n_fail++;
			finish_test();
		end
		r = (s == 1) ? {err2, rd2} : {err1, rd1};
		psel <= 2'h0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input int s, input logic [7:0] a, input logic [31:0] d);
		logic [32:0] r;
		apb(s, 1'b1, a, d, r);
	endtask
	task automatic rdc(input int s, input logic [7:0] a, input logic [31:0] m,
		input logic [32:0] e);
		logic [32:0] r;
		apb(s, 1'b0, a, 32'h0, r);
		chk({r[32], r[31:0] & m}, e);
	endtask
	task automatic bit2(input logic b);
		i_lst_if_2.m_tx <= b;
		i_lst_if_2.m_oe <= ~b;
		repeat (BC) @(posedge clk);
	endtask
	task automatic byte2(input logic [7:0] b);
		bit2(1'b0);
		for (int i = 0; i < 8; i++) bit2(b[i]);
		bit2(1'b1);
	endtask
	task automatic hdr2();
		repeat (13) bit2(1'b0);
		bit2(1'b1);
	endtask
	task automatic bits(input int n);
		repeat (n * BC) @(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		i_lst_if_2.m_tx = 1'b1;
		i_lst_if_2.m_oe = 1'b0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc(0, 8'h04, '1, 33'h000010000);
		rdc(0, 8'h08, '1, 33'h00000ffff);
		rdc(0, 8'h20, '1, 33'h100000000);
		$display("Reset values test done");
		wr(0, 8'h0c, 32'h1);
		wr(0, 8'h1c, 32'hf);
		wr(0, 8'h04, 32'h1);
		wr(0, 8'h00, 32'h1);
		wr(0, 8'h04, 32'h0);
		wr(0, 8'h08, 32'hffff);
		start <= 1'b1;
		for (f = 0; f < 2; f++) begin
			for (k = 0; k < 40 && ready; k++) @(posedge clk);
			if (f == 1)
				start <= 1'b0;
			for (k = 0; k < 4000 && !ready; k++) @(posedge clk);
			chk(33'(k >= 76 * BC && k < 4000), 33'h1);
		end
		chk(33'(n_take), 33'h2);
		rdc(0, 8'h10, 32'hffff, 33'h00000c32a);
		rdc(0, 8'h14, '1, 33'h00000000c);
		chk(33'(irq1), 33'h1);
		wr(0, 8'h18, 32'hf);
		chk(33'(irq1), 33'h0);
		$display("Master frame test done");
		wr(1, 8'h04, 32'h3);
		wr(1, 8'h00, 32'h1);
		wr(1, 8'h0c, 32'h2);
		wr(1, 8'h1c, 32'hf);
		wr(1, 8'h08, 32'hff14);
		hdr2();
		byte2(8'h55);
		bits(4);
		rdc(1, 8'h14, 32'h1, 33'h0);
		bits(8);
		rdc(1, 8'h14, 32'h1, 33'h1);
		rdc(1, 8'h04, 32'hf0000, 33'h000010000);
		rdc(1, 8'h08, '1, 33'h00000ff14);
		wr(1, 8'h04, 32'h2);
		rdc(1, 8'h08, '1, 33'h00000ff14);
		wr(1, 8'h08, 32'hffff);
		wr(1, 8'h18, 32'hf);
		$display("Compare mode test done");
		hdr2();
		byte2(8'h54);
		bits(2);
		rdc(1, 8'h04, 32'hf0000, 33'h000010000);
		rdc(1, 8'h14, 32'h2, 33'h2);
		hdr2();
		byte2(8'h55);
		byte2(8'h2a);
		hdr2();
		byte2(8'h55);
		bits(4);
		rdc(1, 8'h04, 32'hf0000, 33'h000040000);
		bits(12);
		rdc(1, 8'h04, 32'hf0000, 33'h000040000);
		byte2(8'h2b);
		rdc(1, 8'h08, '1, 33'h000005a30);
		rdc(1, 8'h10, 32'hff, 33'h00000002b);
		byte2(8'h11);
		wr(1, 8'h18, 32'hf);
		bits(33);
		rdc(1, 8'h14, 32'h1, 33'h0);
		bits(10);
		rdc(1, 8'h14, 32'h1, 33'h1);
		rdc(1, 8'h04, 32'hf0000, 33'h000010000);
		chk(33'(irq2), 33'h1);
		wr(1, 8'h1c, 32'h0);
		chk(33'(irq2), 33'h0);
		wr(1, 8'h1c, 32'hf);
		wr(1, 8'h18, 32'hf);
		chk(33'(irq2), 33'h0);
		$display("Abort and timeout test done");
		hdr2();
		byte2(8'h55);
		byte2(8'h2c);
		byte2(8'h21);
		byte2(8'h22);
		rdc(1, 8'h04, 32'hf0000, 33'h000080000);
		byte2(8'h23);
		bits(1);
		rdc(1, 8'h04, 32'hf0000, 33'h000010000);
		rdc(1, 8'h14, '1, 33'h00000000c);
		rdc(1, 8'h10, '1, 33'h00000232c);
		$display("Clean restart test done");
		finish_test();
	end
endmodule

// ===== sim/lst_checker.sv
// Purpose: wire checks on the link joining master and slave
// Assumes: bit time of BIT_CYC cycles, master drives low only
// Notes: watches the first link only
`timescale 1ns/1ps
module lst_checker #(
	parameter int BIT_CYC = 16
) (
	// Clock and reset
	input wire logic I_MCLK,
	input wire logic I_RESET,
	// Link signals
	input wire logic m_tx,
	input wire logic m_oe,
	input wire logic s_tx,
	input wire logic s_oe,
	input wire logic bus
);
	localparam int BRK = 13 * BIT_CYC;
	logic [31:0] low_reg;
	logic [31:0] high_reg;
	logic [31:0] since_reg;
	logic delim_reg;
	logic [31:0] low_next;
	logic [31:0] high_next;
	logic [31:0] since_next;
	logic delim_next;
	logic brk_end;

	// ----------------------------------------------------------------
	// Run lengths of the wire
	// ----------------------------------------------------------------
	assign brk_end = m_tx && low_reg == BRK;
	assign low_next = m_tx ? 32'h0 : low_reg + 32'h1;
	assign high_next = m_tx ? high_reg + 32'h1 : 32'h0;
	assign since_next = brk_end ? 32'h0 : since_reg + {31'h0, since_reg != '1};
	assign delim_next = brk_end | (delim_reg & m_tx);
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			low_reg <= 32'h0;
			high_reg <= 32'h0;
			since_reg <= '1;
			delim_reg <= 1'b0;
		end else begin
			low_reg <= low_next;
			high_reg <= high_next;
			since_reg <= since_next;
			delim_reg <= delim_next;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_RESET);
	sequence brk_done_s;
		brk_end;
	endsequence
	sequence short_low_s;
		$rose(m_tx) && low_reg <= 9 * BIT_CYC;
	endsequence
	break_len_a: assert property ($rose(m_tx) && low_reg > 9 * BIT_CYC |-> brk_end)
		else $error("Break run has wrong length");
	bit_len_a: assert property (short_low_s |-> low_reg % BIT_CYC == 0)
		else $error("Low run not whole bit times");
	delim_len_a: assert property ($fell(m_tx) && delim_reg |-> high_reg == BIT_CYC)
		else $error("Delimiter not one bit time");
	frame_gap_a: assert property (brk_done_s |-> since_reg >= 62 * BIT_CYC)
		else $error("Headers closer than frame maximum");
	drive_low_a: assert property (m_oe == !m_tx)
		else $error("Master drives the wire high");
	slave_quiet_a: assert property (!s_oe)
		else $error("Slave drives the wire");
	idle_rel_a: assert property ($fell(I_RESET) |-> m_tx && bus)
		else $error("Wire not idle after reset");
endmodule
